/* rtl/config_control_pkg.sv */
package config_control_pkg;

  localparam int ADDR_W = 12;

  typedef logic [31:0]       word_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [3:0]        strb_t;
  typedef logic [1:0]        resp_t;

  // register map, byte addresses
  localparam addr_t CONFIG_CONTROL_OFFSET = 12'h000;
  localparam addr_t UNLOCK_KEY_OFFSET     = 12'h004;
  localparam addr_t LOCK_STATUS_OFFSET    = 12'h008;
  localparam addr_t PIN_ROUTE_BASE        = 12'h100;
  localparam addr_t MODULE_DISABLE_BASE   = 12'h200;

  // configuration_control field positions
  localparam int PIN_ROUTE_LOCK_BIT           = 13;
  localparam int MODULE_DISABLE_LOCK_BIT      = 12;
  localparam int DEBUG_PORT_ENABLE_BIT        = 3;
  localparam int TWO_WIRE_TEST_OUT_SELECT_BIT = 0;
  localparam word_t READ_ONE_MASK             = 32'h0000_0006;

  // lock_status field positions
  localparam int UNLOCK_OPEN_BIT            = 0;
  localparam int PIN_ROUTE_BLOCKED_BIT      = 1;
  localparam int MODULE_DISABLE_BLOCKED_BIT = 2;

  // unlock keys, values arbitrary
  localparam word_t UNLOCK_KEY_FIRST  = 32'h5A5A_1234;
  localparam word_t UNLOCK_KEY_SECOND = 32'hA5A5_4321;

  localparam resp_t RESP_OKAY   = 2'h0;
  localparam resp_t RESP_SLVERR = 2'h2;

  localparam word_t GATED_WORD_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    UNLOCK_IDLE,
    UNLOCK_FIRST_SEEN,
    UNLOCK_OPEN
  } unlock_e;

  typedef struct packed {
    logic pin_route_lock;
    logic module_disable_lock;
    logic debug_port_enable;
    logic two_wire_test_out_select;
  } cfg_s;

  localparam cfg_s CFG_RESET = '{
    pin_route_lock:           1'b0,
    module_disable_lock:      1'b0,
    debug_port_enable:        1'b1,
    two_wire_test_out_select: 1'b1
  };

  typedef struct packed {
    logic  awvalid;
    addr_t awaddr;
    logic  wvalid;
    word_t wdata;
    strb_t wstrb;
    logic  bready;
    logic  arvalid;
    addr_t araddr;
    logic  rready;
  } axil_req_s;

  typedef struct packed {
    logic  awready;
    logic  wready;
    logic  bvalid;
    resp_t bresp;
    logic  arready;
    logic  rvalid;
    word_t rdata;
    resp_t rresp;
  } axil_rsp_s;

  typedef struct packed {
    logic    aw_held;
    addr_t   aw_addr;
    logic    w_held;
    word_t   w_data;
    strb_t   w_strb;
    logic    bvalid;
    resp_t   bresp;
    logic    rvalid;
    word_t   rdata;
    resp_t   rresp;
    cfg_s    cfg;
    unlock_e unlock;
    logic    pin_route_blocked;
    logic    module_disable_blocked;
  } ctl_state_s;

endpackage

/* rtl/gated_word_register.sv */
`timescale 1ns/1ps
module gated_word_register
#(
  parameter int                WIDTH       = 32,
  parameter logic [WIDTH-1:0]  RESET_VALUE = '0
)
(
  input  wire logic               i_clk,
  input  wire logic               i_sys_rst,
  input  wire logic               i_write,
  input  wire logic [WIDTH-1:0]   i_wdata,
  input  wire logic [WIDTH/8-1:0] i_wstrb,
  output logic      [WIDTH-1:0]   o_value
);

  typedef struct packed {
    logic [WIDTH-1:0] value;
  } word_state_s;

  word_state_s state_reg;
  word_state_s state_next;

  always_comb
  begin
    state_next = state_reg;
    if (i_write)
    begin
      for (int b = 0; b < WIDTH / 8; b++)
      begin
        if (i_wstrb[b])
        begin
          state_next.value[8*b +: 8] = i_wdata[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg.value <= RESET_VALUE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign o_value = state_reg.value;

endmodule

/* rtl/config_control_lock_register.sv */
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module config_control_lock_register
#(
  parameter int N_PIN_ROUTE      = 8,
  parameter int N_MODULE_DISABLE = 4
)
(
  input  wire logic                                              i_clk,
  input  wire logic                                              i_sys_rst,
  input  wire config_control_pkg::axil_req_s                     i_axil,
  output config_control_pkg::axil_rsp_s                          o_axil,
  input  wire logic                                              i_two_wire_mode,
  input  wire logic                                              i_tap_tdo_drive,
  output logic                                                   o_tap_enable,
  output logic                                                   o_tdo_oe,
  output logic                                                   o_two_wire_test_out_select,
  output logic                                                   o_pin_route_lock,
  output logic                                                   o_module_disable_lock,
  output config_control_pkg::word_t [N_PIN_ROUTE-1:0]            o_pin_route_selection,
  output config_control_pkg::word_t [N_MODULE_DISABLE-1:0]       o_module_disable
);
  import config_control_pkg::*;

  ctl_state_s                   state_reg;
  ctl_state_s                   state_next;
  logic [N_PIN_ROUTE-1:0]       pin_route_we;
  logic [N_MODULE_DISABLE-1:0]  module_disable_we;

  // fixed bits are produced here only, so no write can ever reach them
  function automatic word_t cfg_word(input cfg_s c);
    word_t w;
    w = READ_ONE_MASK;
    w[PIN_ROUTE_LOCK_BIT]           = c.pin_route_lock;
    w[MODULE_DISABLE_LOCK_BIT]      = c.module_disable_lock;
    w[DEBUG_PORT_ENABLE_BIT]        = c.debug_port_enable;
    w[TWO_WIRE_TEST_OUT_SELECT_BIT] = c.two_wire_test_out_select;
    return w;
  endfunction

  function automatic word_t status_word(input ctl_state_s s);
    word_t w;
    w = '0;
    w[UNLOCK_OPEN_BIT]            = (s.unlock == UNLOCK_OPEN);
    w[PIN_ROUTE_BLOCKED_BIT]      = s.pin_route_blocked;
    w[MODULE_DISABLE_BLOCKED_BIT] = s.module_disable_blocked;
    return w;
  endfunction

  always_comb
  begin
    o_axil.awready = ~state_reg.aw_held;
    o_axil.wready  = ~state_reg.w_held;
    o_axil.bvalid  = state_reg.bvalid;
    o_axil.bresp   = state_reg.bresp;
    o_axil.arready = ~state_reg.rvalid;
    o_axil.rvalid  = state_reg.rvalid;
    o_axil.rdata   = state_reg.rdata;
    o_axil.rresp   = state_reg.rresp;
  end

  always_comb
  begin
    addr_t rd_addr;
    addr_t wr_addr;
    word_t rd_data;
    logic  rd_hit;
    logic  wr_go;
    logic  wr_hit;
    logic  key_write;
    word_t merged;
    rd_addr           = {i_axil.araddr[ADDR_W-1:2], 2'h0};
    wr_addr           = {state_reg.aw_addr[ADDR_W-1:2], 2'h0};
    rd_data           = '0;
    rd_hit            = 1'b0;
    wr_go             = 1'b0;
    wr_hit            = 1'b0;
    key_write         = 1'b0;
    merged            = cfg_word(state_reg.cfg);
    state_next        = state_reg;
    pin_route_we      = '0;
    module_disable_we = '0;

    // address and data channels are taken independently
    if (i_axil.awvalid && !state_reg.aw_held)
    begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = i_axil.awaddr;
    end
    if (i_axil.wvalid && !state_reg.w_held)
    begin
      state_next.w_held = 1'b1;
      state_next.w_data = i_axil.wdata;
      state_next.w_strb = i_axil.wstrb;
    end
    if (state_reg.bvalid && i_axil.bready)
    begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.rvalid && i_axil.rready)
    begin
      state_next.rvalid = 1'b0;
    end

    // read path
    if (i_axil.arvalid && !state_reg.rvalid)
    begin
      unique case (rd_addr)
        CONFIG_CONTROL_OFFSET:
        begin
          rd_data = cfg_word(state_reg.cfg);
          rd_hit  = 1'b1;
        end
        LOCK_STATUS_OFFSET:
        begin
          rd_data = status_word(state_reg);
          rd_hit  = 1'b1;
        end
        UNLOCK_KEY_OFFSET:
        begin
          rd_hit = 1'b1;
        end
        default:
        begin
          for (int i = 0; i < N_PIN_ROUTE; i++)
          begin
            if (rd_addr == PIN_ROUTE_BASE + addr_t'(4 * i))
            begin
              rd_data = o_pin_route_selection[i];
              rd_hit  = 1'b1;
            end
          end
          for (int i = 0; i < N_MODULE_DISABLE; i++)
          begin
            if (rd_addr == MODULE_DISABLE_BASE + addr_t'(4 * i))
            begin
              rd_data = o_module_disable[i];
              rd_hit  = 1'b1;
            end
          end
        end
      endcase
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_data;
      state_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // write path: acts once both halves are held and no response is pending
    wr_go = state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid;
    for (int b = 0; b < 4; b++)
    begin
      if (state_reg.w_strb[b])
      begin
        merged[8*b +: 8] = state_reg.w_data[8*b +: 8];
      end
    end

    if (wr_go)
    begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      unique case (wr_addr)
        CONFIG_CONTROL_OFFSET:
        begin
          wr_hit = 1'b1;
          state_next.cfg.debug_port_enable        = merged[DEBUG_PORT_ENABLE_BIT];
          state_next.cfg.two_wire_test_out_select = merged[TWO_WIRE_TEST_OUT_SELECT_BIT];
          // lock bits move only inside an open unlock window
          if (state_reg.unlock == UNLOCK_OPEN)
          begin
            state_next.cfg.pin_route_lock      = merged[PIN_ROUTE_LOCK_BIT];
            state_next.cfg.module_disable_lock = merged[MODULE_DISABLE_LOCK_BIT];
          end
          state_next.unlock = UNLOCK_IDLE;
        end
        UNLOCK_KEY_OFFSET:
        begin
          wr_hit    = 1'b1;
          key_write = 1'b1;
          // partial-strobe key writes never count as a key
          if (state_reg.w_strb != 4'hF)
          begin
            state_next.unlock = UNLOCK_IDLE;
          end
          else if (state_reg.w_data == UNLOCK_KEY_FIRST)
          begin
            state_next.unlock = UNLOCK_FIRST_SEEN;
          end
          else if (state_reg.unlock == UNLOCK_FIRST_SEEN &&
                   state_reg.w_data == UNLOCK_KEY_SECOND)
          begin
            state_next.unlock = UNLOCK_OPEN;
          end
          else
          begin
            state_next.unlock = UNLOCK_IDLE;
          end
        end
        LOCK_STATUS_OFFSET:
        begin
          wr_hit = 1'b1;
          if (state_reg.w_strb[0] && state_reg.w_data[PIN_ROUTE_BLOCKED_BIT])
          begin
            state_next.pin_route_blocked = 1'b0;
          end
          if (state_reg.w_strb[0] && state_reg.w_data[MODULE_DISABLE_BLOCKED_BIT])
          begin
            state_next.module_disable_blocked = 1'b0;
          end
        end
        default:
        begin
          for (int i = 0; i < N_PIN_ROUTE; i++)
          begin
            if (wr_addr == PIN_ROUTE_BASE + addr_t'(4 * i))
            begin
              wr_hit = 1'b1;
              if (state_reg.cfg.pin_route_lock)
              begin
                state_next.pin_route_blocked = 1'b1;
              end
              else
              begin
                pin_route_we[i] = 1'b1;
              end
            end
          end
          for (int i = 0; i < N_MODULE_DISABLE; i++)
          begin
            if (wr_addr == MODULE_DISABLE_BASE + addr_t'(4 * i))
            begin
              wr_hit = 1'b1;
              if (state_reg.cfg.module_disable_lock)
              begin
                state_next.module_disable_blocked = 1'b1;
              end
              else
              begin
                module_disable_we[i] = 1'b1;
              end
            end
          end
        end
      endcase
      // the key pair must be back to back; any other write closes a half-open sequence
      if (!key_write && state_reg.unlock == UNLOCK_FIRST_SEEN)
      begin
        state_next.unlock = UNLOCK_IDLE;
      end
      state_next.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg     <= '0;
      state_reg.cfg <= CFG_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // blocked writes still answer OKAY, software sees the drop in lock_status
  for (genvar g = 0; g < N_PIN_ROUTE; g++)
  begin : gen_pin_route
    gated_word_register
    #(
      .WIDTH       (32),
      .RESET_VALUE (GATED_WORD_RESET)
    )
    u_word
    (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_write   (pin_route_we[g]),
      .i_wdata   (state_reg.w_data),
      .i_wstrb   (state_reg.w_strb),
      .o_value   (o_pin_route_selection[g])
    );
  end

  for (genvar g = 0; g < N_MODULE_DISABLE; g++)
  begin : gen_module_disable
    gated_word_register
    #(
      .WIDTH       (32),
      .RESET_VALUE (GATED_WORD_RESET)
    )
    u_word
    (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_write   (module_disable_we[g]),
      .i_wdata   (state_reg.w_data),
      .i_wstrb   (state_reg.w_strb),
      .o_value   (o_module_disable[g])
    );
  end

  assign o_tap_enable               = state_reg.cfg.debug_port_enable;
  assign o_two_wire_test_out_select = state_reg.cfg.two_wire_test_out_select;
  assign o_pin_route_lock           = state_reg.cfg.pin_route_lock;
  assign o_module_disable_lock      = state_reg.cfg.module_disable_lock;

  // tdo only driven with the port on, and in two-wire mode only when selected
  assign o_tdo_oe = i_tap_tdo_drive & state_reg.cfg.debug_port_enable
                  & (~i_two_wire_mode | state_reg.cfg.two_wire_test_out_select);

endmodule

/* sim/config_control_lock_register_assertions.sv */
`timescale 1ns/1ps
module config_control_lock_register_checker
#(
  parameter int N_PIN_ROUTE      = 8,
  parameter int N_MODULE_DISABLE = 4
)
(
  input wire logic                                        i_clk,
  input wire logic                                        i_sys_rst,
  input wire config_control_pkg::axil_req_s               i_axil,
  input wire config_control_pkg::axil_rsp_s               o_axil,
  input wire logic                                        i_two_wire_mode,
  input wire logic                                        i_tap_tdo_drive,
  input wire logic                                        o_tap_enable,
  input wire logic                                        o_tdo_oe,
  input wire logic                                        o_two_wire_test_out_select,
  input wire logic                                        o_pin_route_lock,
  input wire logic                                        o_module_disable_lock,
  input wire config_control_pkg::word_t [N_PIN_ROUTE-1:0]      o_pin_route_selection,
  input wire config_control_pkg::word_t [N_MODULE_DISABLE-1:0] o_module_disable
);
  import config_control_pkg::*;
  addr_t rd_addr_reg;
  addr_t rd_addr_next;
  logic  cfg_read;
  // address stays valid while rvalid is up, arready is low then
  always_comb
  begin
    rd_addr_next = rd_addr_reg;
    if (i_axil.arvalid && o_axil.arready)
      rd_addr_next = i_axil.araddr;
  end
  always_ff @(posedge i_clk)
  begin
    rd_addr_reg <= rd_addr_next;
  end
  assign cfg_read = o_axil.rvalid && (rd_addr_reg[11:2] == CONFIG_CONTROL_OFFSET[11:2]);
  addr_t   aw_seen_reg;
  word_t   w_seen_reg;
  strb_t   w_strb_seen_reg;
  logic    bvalid_d_reg;
  logic    key_addr;
  logic    cfg_addr;
  unlock_e key_model_reg;
  assign key_addr = (aw_seen_reg[11:2] == UNLOCK_KEY_OFFSET[11:2]);
  assign cfg_addr = (aw_seen_reg[11:2] == CONFIG_CONTROL_OFFSET[11:2]);
  // key sequence followed from bus traffic, one step per executed write
  always_ff @(posedge i_clk)
  begin
    if (i_axil.awvalid && o_axil.awready)
      aw_seen_reg <= i_axil.awaddr;
    if (i_axil.wvalid && o_axil.wready)
    begin
      w_seen_reg      <= i_axil.wdata;
      w_strb_seen_reg <= i_axil.wstrb;
    end
    bvalid_d_reg <= o_axil.bvalid;
    if (i_sys_rst)
      key_model_reg <= UNLOCK_IDLE;
    else if (o_axil.bvalid && !bvalid_d_reg)
    begin
      if (key_addr && w_strb_seen_reg == 4'hF && w_seen_reg == UNLOCK_KEY_FIRST)
        key_model_reg <= UNLOCK_FIRST_SEEN;
      else if (key_addr && w_strb_seen_reg == 4'hF && w_seen_reg == UNLOCK_KEY_SECOND
               && key_model_reg == UNLOCK_FIRST_SEEN)
        key_model_reg <= UNLOCK_OPEN;
      else if (key_model_reg != UNLOCK_OPEN || key_addr || cfg_addr)
        key_model_reg <= UNLOCK_IDLE;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_tap_gate;
    (i_tap_tdo_drive && !i_two_wire_mode) |-> (o_tdo_oe == o_tap_enable);
  endproperty
  property p_tdo_gate;
    (i_two_wire_mode && o_tap_enable) |-> (o_tdo_oe == (i_tap_tdo_drive && o_two_wire_test_out_select));
  endproperty
  property p_reset_vals;
    $past(i_sys_rst) |-> (o_tap_enable && o_two_wire_test_out_select
                          && !o_pin_route_lock && !o_module_disable_lock);
  endproperty
  property p_read_ones;
    cfg_read |-> (o_axil.rdata[2:1] == 2'b11);
  endproperty
  property p_read_high;
    cfg_read |-> (o_axil.rdata[31:14] == '0);
  endproperty
  property p_read_mid;
    cfg_read |-> (o_axil.rdata[11:4] == '0);
  endproperty
  property p_pin_guard;
    (!$past(i_sys_rst) && $changed(o_pin_route_selection)) |-> !$past(o_pin_route_lock);
  endproperty
  property p_mod_guard;
    (!$past(i_sys_rst) && $changed(o_module_disable)) |-> !$past(o_module_disable_lock);
  endproperty
  property p_lock_by_write;
    (!$past(i_sys_rst) && ($changed(o_pin_route_lock) || $changed(o_module_disable_lock)))
      |-> ($rose(o_axil.bvalid) && key_model_reg == UNLOCK_OPEN && cfg_addr);
  endproperty
  a_tap_gate: assert property (p_tap_gate) else $error("tap enable gating wrong");
  a_tdo_gate: assert property (p_tdo_gate) else $error("two-wire tdo gating wrong");
  a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");
  a_read_ones: assert property (p_read_ones) else $error("bits 2:1 not one");
  a_read_high: assert property (p_read_high) else $error("bits 31:14 not zero");
  a_read_mid: assert property (p_read_mid) else $error("bits 11:4 not zero");
  a_pin_guard: assert property (p_pin_guard) else $error("pin-route word changed locked");
  a_mod_guard: assert property (p_mod_guard) else $error("module word changed locked");
  a_lock_by_write: assert property (p_lock_by_write) else $error("lock moved without write");
  c_cfg_read: cover property (cfg_read);
  c_pin_lock: cover property ($rose(o_pin_route_lock));
  c_tdo: cover property (o_tdo_oe && i_two_wire_mode);
endmodule

bind config_control_lock_register config_control_lock_register_checker
  #(.N_PIN_ROUTE(N_PIN_ROUTE), .N_MODULE_DISABLE(N_MODULE_DISABLE)) checker_i
(
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_axil(i_axil), .o_axil(o_axil),
  .i_two_wire_mode(i_two_wire_mode), .i_tap_tdo_drive(i_tap_tdo_drive),
  .o_tap_enable(o_tap_enable), .o_tdo_oe(o_tdo_oe),
  .o_two_wire_test_out_select(o_two_wire_test_out_select),
  .o_pin_route_lock(o_pin_route_lock), .o_module_disable_lock(o_module_disable_lock),
  .o_pin_route_selection(o_pin_route_selection), .o_module_disable(o_module_disable)
);

/* sim/config_control_lock_register_tb_top.sv */
`timescale 1ns/1ps
module config_control_lock_register_tb_top;
  import config_control_pkg::*;
  logic        i_clk         = 1'b0;
  logic        i_sys_rst     = 1'b1;
  axil_req_s   req           = '0;
  logic        two_wire_mode = 1'b0;
  logic        tdo_drive     = 1'b0;
  axil_rsp_s   rsp;
  logic        tap_en, tdo_oe, tw_sel, pr_lock, md_lock;
  word_t [7:0] pr_sel;
  word_t [3:0] md_word;
  word_t       rd;
  resp_t       rs;
  int          mismatches    = 0;
  int          comparisons   = 0;

  always #2.5 i_clk = ~i_clk;

  config_control_lock_register #(.N_PIN_ROUTE(8), .N_MODULE_DISABLE(4))
    config_control_lock_register_i
  (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_axil(req), .o_axil(rsp),
    .i_two_wire_mode(two_wire_mode), .i_tap_tdo_drive(tdo_drive), .o_tap_enable(tap_en),
    .o_tdo_oe(tdo_oe), .o_two_wire_test_out_select(tw_sel), .o_pin_route_lock(pr_lock),
    .o_module_disable_lock(md_lock), .o_pin_route_selection(pr_sel), .o_module_disable(md_word)
  );

  task automatic finish_test;
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input word_t seen, input word_t exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_timeout;
    mismatches++;
    $display("mismatch at %0t: bus timeout", $time);
    finish_test();
  endtask

  // write address, data and response ready all offered at once
  task automatic axi_write(input addr_t a, input word_t d);
    bit done;
    done = 1'b0;
    @(posedge i_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(posedge i_clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
      begin
        rs = rsp.bresp;
        req.bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      bus_timeout();
  endtask

  task automatic axi_read(input addr_t a);
    bit done;
    done = 1'b0;
    @(posedge i_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(posedge i_clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
      begin
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done)
      bus_timeout();
  endtask

  task automatic unlock;
    axi_write(UNLOCK_KEY_OFFSET, UNLOCK_KEY_FIRST);
    axi_write(UNLOCK_KEY_OFFSET, UNLOCK_KEY_SECOND);
  endtask

  task automatic t_reset;
    axi_read(CONFIG_CONTROL_OFFSET);
    check(rd, 32'h0000_000F);
    check({tap_en, tw_sel, pr_lock, md_lock}, 4'hC);
    axi_read(12'hFFC);
    check(rs, RESP_SLVERR);
  endtask

  task automatic t_fields;
    axi_write(CONFIG_CONTROL_OFFSET, 32'hFFFF_FFFF);
    axi_read(CONFIG_CONTROL_OFFSET);
    check(rd, 32'h0000_000F);
    axi_write(CONFIG_CONTROL_OFFSET, 32'h0000_0000);
    axi_read(CONFIG_CONTROL_OFFSET);
    check(rd, 32'h0000_0006);
    // every mix of enable, select and two-wire mode
    for (int k = 0; k < 8; k++)
    begin
      axi_write(CONFIG_CONTROL_OFFSET, {28'h0, k[1], 2'b00, k[0]});
      two_wire_mode <= k[2];
      tdo_drive     <= 1'b1;
      @(posedge i_clk);
      check(tap_en, k[1]);
      check(tdo_oe, k[1] & (~k[2] | k[0]));
    end
  endtask

  task automatic t_locks;
    axi_write(PIN_ROUTE_BASE, 32'h1234_5678);
    check(pr_sel[0], 32'h1234_5678);
    // an unrelated write between the keys must spoil the unlock
    axi_write(UNLOCK_KEY_OFFSET, UNLOCK_KEY_FIRST);
    axi_write(PIN_ROUTE_BASE + 12'h4, 32'h0000_00AA);
    axi_write(UNLOCK_KEY_OFFSET, UNLOCK_KEY_SECOND);
    axi_write(CONFIG_CONTROL_OFFSET, 32'h0000_300F);
    check({pr_lock, md_lock}, 2'b00);
    check(pr_sel[1], 32'h0000_00AA);
    unlock();
    axi_write(CONFIG_CONTROL_OFFSET, 32'h0000_200F);
    check({pr_lock, md_lock}, 2'b10);
    axi_write(PIN_ROUTE_BASE, 32'hFFFF_0000);
    check(rs, RESP_OKAY);
    check(pr_sel[0], 32'h1234_5678);
    axi_write(MODULE_DISABLE_BASE + 12'hC, 32'h0000_0F0F);
    check(md_word[3], 32'h0000_0F0F);
    unlock();
    axi_read(LOCK_STATUS_OFFSET);
    check(rd, 32'h0000_0003);
    axi_write(CONFIG_CONTROL_OFFSET, 32'h0000_100F);
    check({pr_lock, md_lock}, 2'b01);
    axi_write(MODULE_DISABLE_BASE + 12'hC, 32'h0000_0000);
    check(md_word[3], 32'h0000_0F0F);
    axi_write(PIN_ROUTE_BASE + 12'h1C, 32'h0000_0055);
    check(pr_sel[7], 32'h0000_0055);
    axi_read(CONFIG_CONTROL_OFFSET);
    check(rd, 32'h0000_100F);
  endtask

  // sticky blocked flags clear by writing ones; unmapped writes answer an error
  task automatic t_status;
    axi_read(LOCK_STATUS_OFFSET);
    check(rd, 32'h0000_0006);
    axi_write(LOCK_STATUS_OFFSET, 32'h0000_0006);
    check(rs, RESP_OKAY);
    axi_read(LOCK_STATUS_OFFSET);
    check(rd, 32'h0000_0000);
    axi_write(12'hFFC, 32'h0000_0000);
    check(rs, RESP_SLVERR);
    axi_read(UNLOCK_KEY_OFFSET);
    check(rd, 32'h0000_0000);
  endtask

  // reset in mid-run with the module-disable lock set and a gated word written
  task automatic t_reset_again;
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    check({tap_en, tw_sel, pr_lock, md_lock}, 4'hC);
    check(md_word[3], 32'h0000_0000);
    axi_read(CONFIG_CONTROL_OFFSET);
    check(rd, 32'h0000_000F);
  endtask

  initial
  begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_fields();
    t_locks();
    t_status();
    t_reset_again();
    finish_test();
  end
endmodule
